// file: hw/mmc_core.sv
// address map, program counter and register file of the 8-bit core
// Behaviour
// RQ1 - a non-branching instruction occupies exactly one clock
// RQ2 - branches and other flow changes take two cycles, everything else one
// RQ3 - program counter is 11 bits, covering 2K words
// RQ4 - after reset the program counter is 0x000
// RQ5 - a taken interrupt forces the program counter to 0x003
// RQ6 - call and jump reach all program memory straight from the operand
// RQ7 - 0x7f0 to 0x7ff hold configuration and are never executed
// RQ8 - six-deep return stack, pushed by calls and interrupts, popped by returns
// RQ9 - data 0x40 to 0x7f is general RAM, direct or through the pointer
// RQ10 - io-setup space at 0x08 0x09 0x17 0x19 0x23 is separate from data space
// RQ11 - unimplemented bits read zero and ignore writes
// RQ12 - first pwm 16-bit period sits at io-setup 0x17 low and 0x19 high
// RQ13 - data address zero acts on the word the pointer register selects
// RQ14 - data 0x02 shows pc low byte; writing it branches
module mmc_core (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	// instruction-side command
	input wire mmc_pkg::mmc_op_t i_op,
	input wire logic [mmc_pkg::DATA_AW-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [mmc_pkg::PC_W-1:0] i_target,
	input wire logic i_irq,
	// sequencing
	output logic o_ready,
	output logic o_irq_ack,
	output logic [mmc_pkg::PC_W-1:0] o_pc,
	output logic [3:0] o_stack_level,
	// read answer
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	// register contents to the rest of the core
	output logic [7:0] o_status,
	output logic [7:0] o_ptr,
	output logic [7:0] o_port_ctrl,
	output logic [7:0] o_pad_mode_a,
	output logic [7:0] o_pad_mode_b,
	output logic [15:0] o_pwm_a_period,
	output logic [15:0] o_pwm_a_duty,
	output logic [7:0] o_pwm_b_period,
	output logic [7:0] o_pwm_b_duty
);
	import mmc_pkg::*;

	// ******************************
	// state
	// ******************************
	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic busy;
		logic [7:0] rdata;
		logic rvalid;
		logic [7:0] status;
		logic [7:0] ptr;
		logic [7:0] port_ctrl;
		logic [7:0] duty_a_lo;
		logic [7:0] duty_a_hi;
		logic [7:0] duty_b;
		logic [7:0] pad_a;
		logic [7:0] pad_b;
		logic [7:0] per_a_lo;
		logic [7:0] per_a_hi;
		logic [7:0] per_b;
		logic [63:0][7:0] gpr;
	} mmc_state_t;

	mmc_state_t s_q;
	mmc_state_t s_d;
	logic [PC_W-1:0] seq_w;
	logic [PC_W-1:0] stk_top;
	logic [3:0] stk_level;
	logic push;
	logic pop;
	logic irq_ack;
	logic [6:0] ea;
	logic [7:0] rd_data;
	logic [7:0] rd_io;
	logic [PC_W-1:0] pcl_tgt;

	// ******************************
	// return stack
	// ******************************
	mmc_ret_stack #(
		.DEPTH(STACK_DEPTH),
		.W(PC_W)
	) u_stack (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_push(push),
		.i_pop(pop),
		.i_push_data(seq_w),
		.o_top(stk_top),
		.o_level(stk_level)
	);

	// ******************************
	// next state
	// ******************************
	always_comb begin
		s_d = s_q;
		s_d.busy = 1'b0;
		s_d.rvalid = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		irq_ack = 1'b0;
		// sequential fetch skips the configuration area
		seq_w = (s_q.pc + PC_STEP >= CFG_LO) ? RESET_VEC : s_q.pc + PC_STEP; // RQ7 RQ3
		ea = (i_addr == A_IND) ? s_q.ptr[6:0] : i_addr; // RQ13
		pcl_tgt = {s_q.pc[10:8], i_wdata};
		// pointer at zero reads zero, avoiding a self loop
		rd_data = 8'h00;
		if (ea == A_PC_LOW) begin
			rd_data = s_q.pc[7:0]; // RQ14
		end else if (ea == A_STATUS) begin
			rd_data = s_q.status & STATUS_MASK; // RQ11
		end else if (ea == A_PTR) begin
			rd_data = s_q.ptr & PTR_MASK; // RQ11
		end else if (ea == A_PORT_CTRL) begin
			rd_data = s_q.port_ctrl & PAD_MASK;
		end else if (ea == A_DUTY_A_LO) begin
			rd_data = s_q.duty_a_lo;
		end else if (ea == A_DUTY_A_HI) begin
			rd_data = s_q.duty_a_hi;
		end else if (ea == A_DUTY_B) begin
			rd_data = s_q.duty_b;
		end else if (ea >= GPR_LO) begin
			rd_data = s_q.gpr[ea[5:0]]; // RQ9
		end
		rd_io = 8'h00;
		if (i_addr == IO_PAD_A) begin
			rd_io = s_q.pad_a & PAD_MASK; // RQ10 RQ11
		end else if (i_addr == IO_PAD_B) begin
			rd_io = s_q.pad_b & PAD_MASK;
		end else if (i_addr == IO_PER_A_LO) begin
			rd_io = s_q.per_a_lo; // RQ12
		end else if (i_addr == IO_PER_A_HI) begin
			rd_io = s_q.per_a_hi; // RQ12
		end else if (i_addr == IO_PER_B) begin
			rd_io = s_q.per_b;
		end
		// second cycle of a branch: hold the target, ignore the command
		if (s_q.busy) begin
			s_d.pc = s_q.pc; // RQ2
		end else begin
			case (i_op)
				OP_NOP: begin
					if (i_irq) begin
						push = 1'b1; // RQ8
						irq_ack = 1'b1;
						s_d.pc = IRQ_VEC; // RQ5
						s_d.busy = 1'b1;
					end else begin
						s_d.pc = seq_w; // RQ1
					end
				end
				OP_RD: begin
					s_d.pc = seq_w; // RQ1
					s_d.rdata = rd_data;
					s_d.rvalid = 1'b1;
				end
				OP_WR: begin
					s_d.pc = seq_w;
					if (ea == A_PC_LOW && pcl_tgt < CFG_LO) begin
						s_d.pc = pcl_tgt; // RQ14
						s_d.busy = 1'b1;
					end else if (ea == A_STATUS) begin
						s_d.status = i_wdata & STATUS_MASK; // RQ11
					end else if (ea == A_PTR) begin
						s_d.ptr = i_wdata & PTR_MASK;
					end else if (ea == A_PORT_CTRL) begin
						s_d.port_ctrl = i_wdata & PAD_MASK;
					end else if (ea == A_DUTY_A_LO) begin
						s_d.duty_a_lo = i_wdata;
					end else if (ea == A_DUTY_A_HI) begin
						s_d.duty_a_hi = i_wdata;
					end else if (ea == A_DUTY_B) begin
						s_d.duty_b = i_wdata;
					end else if (ea >= GPR_LO) begin
						s_d.gpr[ea[5:0]] = i_wdata; // RQ9 RQ13
					end
				end
				OP_IOR: begin
					s_d.pc = seq_w;
					s_d.rdata = rd_io; // RQ10
					s_d.rvalid = 1'b1;
				end
				OP_IOW: begin
					s_d.pc = seq_w;
					if (i_addr == IO_PAD_A) begin
						s_d.pad_a = i_wdata & PAD_MASK; // RQ10
					end else if (i_addr == IO_PAD_B) begin
						s_d.pad_b = i_wdata & PAD_MASK;
					end else if (i_addr == IO_PER_A_LO) begin
						s_d.per_a_lo = i_wdata; // RQ12
					end else if (i_addr == IO_PER_A_HI) begin
						s_d.per_a_hi = i_wdata; // RQ12
					end else if (i_addr == IO_PER_B) begin
						s_d.per_b = i_wdata;
					end
				end
				OP_JMP, OP_CALL: begin
					// a target in the configuration area is refused
					if (i_target < CFG_LO) begin
						s_d.pc = i_target; // RQ6 RQ7
						s_d.busy = 1'b1;
						push = (i_op == OP_CALL); // RQ8
					end else begin
						s_d.pc = seq_w;
					end
				end
				OP_RET: begin
					pop = 1'b1; // RQ8
					s_d.pc = stk_top;
					s_d.busy = 1'b1;
				end
				default: begin
					s_d.pc = seq_w;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_q <= '0;
			s_q.pc <= RESET_VEC; // RQ4
		end else begin
			s_q <= s_d;
		end
	end

	// ******************************
	// outputs
	// ******************************
	assign o_ready = !s_q.busy;
	assign o_irq_ack = irq_ack;
	assign o_pc = s_q.pc;
	assign o_stack_level = stk_level;
	assign o_rdata = s_q.rdata;
	assign o_rvalid = s_q.rvalid;
	assign o_status = s_q.status;
	assign o_ptr = s_q.ptr;
	assign o_port_ctrl = s_q.port_ctrl;
	assign o_pad_mode_a = s_q.pad_a;
	assign o_pad_mode_b = s_q.pad_b;
	assign o_pwm_a_period = {s_q.per_a_hi, s_q.per_a_lo};
	assign o_pwm_a_duty = {s_q.duty_a_hi, s_q.duty_a_lo};
	assign o_pwm_b_period = s_q.per_b;
	assign o_pwm_b_duty = s_q.duty_b;

	// ******************************
	// checks
	// ******************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);

	sequence s_call;
		o_ready && i_op == OP_CALL && i_target < CFG_LO;
	endsequence
	sequence s_ret;
		o_ready && i_op == OP_RET;
	endsequence
	// store, one slot with no write, then load of the same word
	sequence s_gpr_wr_rd;
		o_ready && i_op == OP_WR && i_addr >= GPR_LO
		##1 i_op != OP_WR
		##1 o_ready && i_op == OP_RD && i_addr == $past(i_addr, 2);
	endsequence
	sequence s_ind_wr_rd;
		o_ready && i_op == OP_WR && i_addr == A_IND && o_ptr[6:0] >= GPR_LO
		##1 i_op != OP_WR
		##1 o_ready && i_op == OP_RD && i_addr == $past(o_ptr[6:0], 2);
	endsequence

	property p_one_cycle;
		o_ready && i_op inside {OP_RD, OP_IOR, OP_IOW}
		|=> o_ready && o_pc == (($past(o_pc) + PC_STEP >= CFG_LO) ? RESET_VEC
			: $past(o_pc) + PC_STEP);
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("plain op did not step pc"); // RQ1

	property p_branch_two;
		o_ready && i_op == OP_JMP && i_target < CFG_LO |=> !o_ready ##1 o_ready;
	endproperty
	a_branch_two: assert property (p_branch_two) else $error("branch not two cycles"); // RQ2

	property p_reset_vec;
		$rose(i_reset_n) |-> o_pc == RESET_VEC;
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("pc not at reset vector"); // RQ4

	property p_irq_vec;
		o_irq_ack |=> o_pc == IRQ_VEC && !o_ready ##1 o_pc == IRQ_VEC && o_ready;
	endproperty
	a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector missed"); // RQ5

	property p_jump_reach;
		o_ready && i_op inside {OP_JMP, OP_CALL} && i_target < CFG_LO
		|=> o_pc == $past(i_target);
	endproperty
	a_jump_reach: assert property (p_jump_reach) else $error("jump target not loaded"); // RQ6

	property p_cfg_area;
		o_pc < CFG_LO;
	endproperty
	a_cfg_area: assert property (p_cfg_area) else $error("pc in configuration area"); // RQ7

	property p_call_ret;
		s_call ##2 s_ret |=> ##1 o_pc == $past(seq_w, 4) && o_ready;
	endproperty
	a_call_ret: assert property (p_call_ret) else $error("return address wrong"); // RQ8

	property p_gpr;
		s_gpr_wr_rd |=> o_rvalid && o_rdata == $past(i_wdata, 3);
	endproperty
	a_gpr: assert property (p_gpr) else $error("general ram readback wrong"); // RQ9

	property p_io_space;
		o_ready && i_op == OP_IOW && i_addr == IO_PER_A_LO
		|=> o_pwm_a_period[7:0] == $past(i_wdata) && $stable(o_pwm_a_duty);
	endproperty
	a_io_space: assert property (p_io_space) else $error("io-setup write misplaced"); // RQ10 RQ12

	property p_unimpl;
		o_ready && i_op == OP_RD && i_addr == A_STATUS |=> o_rvalid && o_rdata[7:6] == 2'b00;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bits not zero"); // RQ11

	property p_indirect;
		s_ind_wr_rd |=> o_rvalid && o_rdata == $past(i_wdata, 3);
	endproperty
	a_indirect: assert property (p_indirect) else $error("indirect write lost"); // RQ13

	property p_pc_low;
		o_ready && i_op == OP_WR && i_addr == A_PC_LOW && {o_pc[10:8], i_wdata} < CFG_LO
		|=> !o_ready && o_pc[7:0] == $past(i_wdata);
	endproperty
	a_pc_low: assert property (p_pc_low) else $error("pc low write did not branch"); // RQ14
endmodule : mmc_core

// file: hw/mmc_pkg.sv
// constants and types shared by the memory-map core and its return stack
package mmc_pkg;
	// ******************************
	// program space
	// ******************************
	localparam int PC_W = 11;
	localparam int STACK_DEPTH = 6;
	localparam logic [10:0] RESET_VEC = 11'h000;
	localparam logic [10:0] IRQ_VEC = 11'h003;
	localparam logic [10:0] CFG_LO = 11'h7f0;
	localparam logic [10:0] PC_STEP = 11'h001;
	// ******************************
	// data space
	// ******************************
	localparam int DATA_AW = 7;
	localparam logic [6:0] A_IND = 7'h00;
	localparam logic [6:0] A_PC_LOW = 7'h02;
	localparam logic [6:0] A_STATUS = 7'h03;
	localparam logic [6:0] A_PTR = 7'h04;
	localparam logic [6:0] A_PORT_CTRL = 7'h09;
	localparam logic [6:0] A_DUTY_A_LO = 7'h17;
	localparam logic [6:0] A_DUTY_A_HI = 7'h19;
	localparam logic [6:0] A_DUTY_B = 7'h23;
	localparam logic [6:0] GPR_LO = 7'h40;
	// ******************************
	// io-setup space
	// ******************************
	localparam logic [6:0] IO_PAD_A = 7'h08;
	localparam logic [6:0] IO_PAD_B = 7'h09;
	localparam logic [6:0] IO_PER_A_LO = 7'h17;
	localparam logic [6:0] IO_PER_A_HI = 7'h19;
	localparam logic [6:0] IO_PER_B = 7'h23;
	// ******************************
	// implemented-bit masks and reset value
	// ******************************
	localparam logic [7:0] STATUS_MASK = 8'h3f;
	localparam logic [7:0] PTR_MASK = 8'h7f;
	localparam logic [7:0] PAD_MASK = 8'h3f;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// ******************************
	// instruction operations seen by the map
	// ******************************
	typedef enum logic [2:0] {
		OP_NOP,
		OP_RD,
		OP_WR,
		OP_IOR,
		OP_IOW,
		OP_JMP,
		OP_CALL,
		OP_RET
	} mmc_op_t;
endpackage : mmc_pkg

// file: hw/mmc_ret_stack.sv
// hardware return-address stack, shift organised
module mmc_ret_stack #(
	parameter int DEPTH = mmc_pkg::STACK_DEPTH,
	parameter int W = mmc_pkg::PC_W
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	// stack control
	input wire logic i_push,
	input wire logic i_pop,
	input wire logic [W-1:0] i_push_data,
	// stack state
	output logic [W-1:0] o_top,
	output logic [3:0] o_level
);
	import mmc_pkg::*;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] ent;
		logic [3:0] level;
	} mmc_stk_t;

	mmc_stk_t s_q;
	mmc_stk_t s_d;

	// overflow drops the oldest entry, underflow reads zeros
	always_comb begin
		s_d = s_q;
		if (i_push) begin
			s_d.ent = {s_q.ent[DEPTH-2:0], i_push_data};
			if (s_q.level != 4'(DEPTH)) begin
				s_d.level = s_q.level + 4'h1;
			end
		end else if (i_pop) begin
			s_d.ent = {{W{1'b0}}, s_q.ent[DEPTH-1:1]};
			if (s_q.level != 4'h0) begin
				s_d.level = s_q.level - 4'h1;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_top = s_q.ent[0];
	assign o_level = s_q.level;
endmodule : mmc_ret_stack

// file: bench/mcu_memory_map_core_bench.sv
// self-checking bench for the memory-map core
module mcu_memory_map_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import mmc_pkg::*;
	// ******************************
	// signals
	// ******************************
	localparam int CYC_LIMIT = 3000;
	logic i_clk_sys = 1'b0;
	logic i_reset_n;
	mmc_op_t i_op;
	logic [6:0] i_addr;
	logic [7:0] i_wdata;
	logic [10:0] i_target;
	logic i_irq;
	logic o_ready, o_irq_ack, o_rvalid;
	logic [10:0] o_pc;
	logic [3:0] o_stack_level;
	logic [7:0] o_rdata, o_status, o_ptr, o_port_ctrl, o_pad_mode_a, o_pad_mode_b;
	logic [7:0] o_pwm_b_period, o_pwm_b_duty;
	logic [15:0] o_pwm_a_period, o_pwm_a_duty;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [10:0] pc_at, tg;
	logic ack_at;
	logic [6:0] a;
	logic [7:0] d;
	logic [10:0] ret_q[$];
	logic [6:0] io_a [5] = '{IO_PAD_A, IO_PAD_B, IO_PER_A_LO, IO_PER_A_HI, IO_PER_B};
	logic [7:0] io_m [5] = '{PAD_MASK, PAD_MASK, 8'hff, 8'hff, 8'hff};
	logic [7:0] io_v [5];
	logic [7:0] dt_v [5];

	mmc_core dut_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_op(i_op),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_target(i_target), .i_irq(i_irq),
		.o_ready(o_ready), .o_irq_ack(o_irq_ack), .o_pc(o_pc),
		.o_stack_level(o_stack_level), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
		.o_status(o_status), .o_ptr(o_ptr), .o_port_ctrl(o_port_ctrl),
		.o_pad_mode_a(o_pad_mode_a), .o_pad_mode_b(o_pad_mode_b),
		.o_pwm_a_period(o_pwm_a_period), .o_pwm_a_duty(o_pwm_a_duty),
		.o_pwm_b_period(o_pwm_b_period), .o_pwm_b_duty(o_pwm_b_duty));

	always #4 i_clk_sys = ~i_clk_sys;
	// ******************************
	// helpers
	// ******************************
	function automatic logic [10:0] next_pc(input logic [10:0] p);
		return (p >= 11'h7ef) ? RESET_VEC : p + PC_STEP;
	endfunction : next_pc

	task automatic chk_data(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_data

	task automatic chk_pc(input string what, input logic [10:0] exp);
		cmp_count++;
		if (o_pc !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, o_pc);
		end
	endtask : chk_pc

	task automatic chk_flag(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_flag

	// one op, then a nop; returns just after the taking edge
	task automatic cmd(input mmc_op_t op, input logic [6:0] ad, input logic [7:0] wd,
			input logic [10:0] t, input logic irq);
		@(posedge i_clk_sys);
		i_op <= op;
		i_addr <= ad;
		i_wdata <= wd;
		i_target <= t;
		i_irq <= irq;
		@(negedge i_clk_sys);
		pc_at = o_pc;
		ack_at = o_irq_ack;
		@(posedge i_clk_sys);
		i_op <= OP_NOP;
		i_irq <= 1'b0;
		#1;
	endtask : cmd

	task automatic rd_chk(input mmc_op_t op, input logic [6:0] ad, input logic [7:0] exp);
		cmd(op, ad, 8'h00, 11'h000, 1'b0);
		chk_flag("rvalid", 1'b1, o_rvalid);
		chk_data("rdata", 16'(exp), 16'(o_rdata));
	endtask : rd_chk

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize

	// hang guard, ceiling well above the sequence length
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == CYC_LIMIT) begin
			err_total++;
			summarize();
		end
	end
	// ******************************
	// sequence
	// ******************************
	initial begin
		void'($urandom(32'h05483e63));
		i_reset_n <= 1'b0;
		i_op <= OP_NOP;
		i_addr <= 7'h00;
		i_wdata <= 8'h00;
		i_target <= 11'h000;
		i_irq <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		#1;
		chk_pc("pc reset", RESET_VEC);
		chk_flag("ready reset", 1'b1, o_ready);
		for (int i = 0; i < 4; i++) begin
			cmd(OP_NOP, 7'h00, 8'h00, 11'h000, 1'b0);
			chk_pc("pc step", next_pc(pc_at));
		end
		cmd(OP_WR, A_STATUS, 8'hff, 11'h000, 1'b0);
		chk_data("status", 16'(STATUS_MASK), 16'(o_status));
		rd_chk(OP_RD, A_STATUS, STATUS_MASK);
		cmd(OP_WR, A_PTR, 8'hff, 11'h000, 1'b0);
		chk_data("pointer", 16'(PTR_MASK), 16'(o_ptr));
		for (int i = 0; i < 6; i++) begin
			a = GPR_LO + 7'($urandom_range(0, 63));
			d = 8'($urandom);
			cmd(OP_WR, a, d, 11'h000, 1'b0);
			rd_chk(OP_RD, a, d);
			cmd(OP_WR, A_PTR, {1'b0, a}, 11'h000, 1'b0);
			chk_flag("rvalid drop", 1'b0, o_rvalid);
			rd_chk(OP_RD, A_IND, d);
			cmd(OP_WR, A_IND, ~d, 11'h000, 1'b0);
			rd_chk(OP_RD, a, ~d);
		end
		cmd(OP_WR, A_PTR, 8'h00, 11'h000, 1'b0);
		rd_chk(OP_RD, A_IND, 8'h00);
		for (int i = 0; i < 5; i++) begin
			io_v[i] = 8'($urandom) | 8'hc0;
			dt_v[i] = ~io_v[i];
			cmd(OP_IOW, io_a[i], io_v[i], 11'h000, 1'b0);
			rd_chk(OP_IOR, io_a[i], io_v[i] & io_m[i]);
		end
		for (int i = 0; i < 5; i++) begin
			cmd(OP_WR, io_a[i], dt_v[i], 11'h000, 1'b0);
		end
		for (int i = 0; i < 5; i++) begin
			rd_chk(OP_IOR, io_a[i], io_v[i] & io_m[i]);
		end
		chk_data("pwm a period", {io_v[3], io_v[2]}, o_pwm_a_period);
		chk_data("pwm a duty", {dt_v[3], dt_v[2]}, o_pwm_a_duty);
		chk_data("pwm b period", 16'(io_v[4]), 16'(o_pwm_b_period));
		chk_data("pwm b duty", 16'(dt_v[4]), 16'(o_pwm_b_duty));
		chk_data("pad a", 16'(io_v[0] & PAD_MASK), 16'(o_pad_mode_a));
		chk_data("pad b", 16'(io_v[1] & PAD_MASK), 16'(o_pad_mode_b));
		chk_data("port ctrl", 16'(dt_v[1] & PAD_MASK), 16'(o_port_ctrl));
		// reserved targets, tried while the stack is empty
		for (int i = 0; i < 2; i++) begin
			cmd(i ? OP_CALL : OP_JMP, 7'h00, 8'h00, CFG_LO + 11'(i * 15), 1'b0);
			chk_pc("reserved target", next_pc(pc_at));
			chk_flag("reserved ready", 1'b1, o_ready);
			chk_data("reserved level", 16'h0000, 16'(o_stack_level));
		end
		for (int i = 0; i < 6; i++) begin
			tg = (i == 0) ? 11'h7ef : 11'($urandom_range(0, 11'h7ef));
			cmd(OP_JMP, 7'h00, 8'h00, tg, 1'b0);
			chk_pc("jump target", tg);
			chk_flag("branch dead cycle", 1'b0, o_ready);
			cmd(OP_NOP, 7'h00, 8'h00, 11'h000, 1'b0);
			chk_pc("after jump", next_pc(tg));
			chk_flag("ready again", 1'b1, o_ready);
		end
		tg = 11'h100;
		cmd(OP_JMP, 7'h00, 8'h00, tg, 1'b0);
		rd_chk(OP_RD, A_PC_LOW, tg[7:0]);
		d = 8'($urandom);
		cmd(OP_WR, A_PC_LOW, d, 11'h000, 1'b0);
		chk_pc("pc low write", {pc_at[10:8], d});
		chk_flag("pc low dead cycle", 1'b0, o_ready);
		// seven calls overflow a six-deep stack
		for (int i = 0; i < 7; i++) begin
			tg = 11'($urandom_range(0, 11'h7ef));
			cmd(OP_CALL, 7'h00, 8'h00, tg, 1'b0);
			ret_q.push_back(next_pc(pc_at));
			chk_pc("call target", tg);
			chk_data("call level", 16'((i < 6) ? i + 1 : 6), 16'(o_stack_level));
		end
		void'(ret_q.pop_front());
		for (int i = 0; i < 6; i++) begin
			cmd(OP_RET, 7'h00, 8'h00, 11'h000, 1'b0);
			chk_pc("return", ret_q.pop_back());
			chk_data("return level", 16'(5 - i), 16'(o_stack_level));
		end
		cmd(OP_RET, 7'h00, 8'h00, 11'h000, 1'b0);
		chk_pc("empty return", RESET_VEC);
		cmd(OP_RD, GPR_LO, 8'h00, 11'h000, 1'b1);
		chk_flag("irq held", 1'b0, ack_at);
		cmd(OP_NOP, 7'h00, 8'h00, 11'h000, 1'b1);
		tg = next_pc(pc_at);
		chk_flag("irq ack", 1'b1, ack_at);
		chk_pc("irq vector", IRQ_VEC);
		chk_data("irq level", 16'h0001, 16'(o_stack_level));
		cmd(OP_RET, 7'h00, 8'h00, 11'h000, 1'b0);
		chk_pc("irq return", tg);
		// second reset with a stacked call
		cmd(OP_CALL, 7'h00, 8'h00, 11'h050, 1'b0);
		@(posedge i_clk_sys);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		#1;
		chk_pc("pc rereset", RESET_VEC);
		chk_data("level rereset", 16'h0000, 16'(o_stack_level));
		@(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		#1;
		chk_pc("first fetch", RESET_VEC);
		@(posedge i_clk_sys);
		#1;
		chk_pc("step after reset", RESET_VEC + PC_STEP);
		summarize();
	end
endmodule : mcu_memory_map_core_bench
